// ===== hw/fiber_regs_defines.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef FIBER_REGS_DEFINES_SVH
`define FIBER_REGS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define IDX_LINK_LOSS 12'h1ec
`define IDX_FIBER_PATH_CONTROL 12'hc00
`define IDX_FIBER_PATH_STATUS 12'hc01
`define IDX_MODE_CFG 12'hc10
`define ADDR_LINK_LOSS 14'h07b0
`define ADDR_FIBER_PATH_CONTROL 14'h3000
`define ADDR_FIBER_PATH_STATUS 14'h3004
`define ADDR_MODE_CFG 14'h3040

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_LINK_LOSS 16'h1ffd
`define RST_FIBER_PATH_CONTROL 16'h1140
`define RST_FIBER_PATH_STATUS 16'h6149
`define RST_MODE_CFG 16'h0000

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define BIT_SOFT_RESET 15
`define BIT_LOOPBACK 14
`define BIT_SPEED_LOW 13
`define BIT_NEG_EN 12
`define BIT_POWER_DOWN 11
`define BIT_ISOLATE 10
`define BIT_NEG_RESTART 9
`define BIT_DUPLEX 8
`define BIT_COL_TEST 7
`define BIT_SPEED_HIGH 6
`define BIT_LINK_LOSS_OFF 0

// ----------------------------------------------------------------------
// Timing: soft reset pulse lasts this long
// ----------------------------------------------------------------------
`define SOFT_RESET_NS 400
`define CLK_PERIOD_NS 50
`define SOFT_RESET_CYCLES ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== hw/fiber_regs_pkg.sv
// Types shared by the fiber path register bank
package fiber_regs_pkg;

    // Operating modes that decide which controls apply
    typedef enum logic [2:0] {
        mode_thousand_x,
        mode_hundred_fx,
        mode_mii_hundred_fx,
        mode_parallel_to_serial_bridge,
        mode_serial_to_parallel_bridge,
        mode_media_converter
    } op_mode_type;

    typedef enum logic [1:0] {
        speed_ten,
        speed_hundred,
        speed_thousand,
        speed_reserved
    } speed_code_type;

    // Decoded controls toward the datapath
    typedef struct packed {
        logic fiber_soft_reset;
        logic mac_side_loopback;
        speed_code_type speed;
        logic negotiation_enable;
        logic serial_power_down;
        logic mac_port_isolate;
        logic negotiation_restart;
        logic forced_duplex;
        logic link_loss_enable;
    } path_ctrl_type;

    // Strap inputs sampled after reset
    typedef struct packed {
        logic speed_code_high;
        logic speed_code_low;
        logic negotiation_enable;
    } strap_type;

endpackage : fiber_regs_pkg

// ===== hw/pulse_stretch.sv
// Counter that holds a request high for a fixed number of cycles
`timescale 1ns/1ps
module pulse_stretch #(
    parameter int unsigned CYCLES = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic start,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic busy;
        logic done;
    } st_type;

    st_type st_ff;
    st_type nxt_st;

    // ------------------------------------------------------------------
    // Count down from start; done pulses in the cycle after the count reaches zero
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (start && !st_ff.busy)
        begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt = 16'(CYCLES - 1);
        end
        else if (st_ff.busy)
        begin
            if (st_ff.cnt == 16'h0000)
            begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
            else
                nxt_st.cnt = st_ff.cnt - 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

    assign busy = st_ff.busy;
    assign done = st_ff.done;
endmodule : pulse_stretch

// ===== hw/fiber_sgmii_control_regs.sv
// Fiber/SGMII control and status register bank behind AXI4-Lite
//
// Function
// - link-loss off bit, resets one (disabled)
// - bit 15 resets fiber path, self-clears
// - bit 14 enables MAC-side loopback
// - speed code {bit6,bit13}, strap preset
// - speed high bit applies only without negotiation
// - bit 12 negotiation enable, strap overridable
// - bit 11 powers down, holds logic reset
// - bit 10 isolates MAC, not serial-to-parallel
// - bit 9 restarts negotiation, self-clears
// - bit 8 duplex, only MII-FX mode
// - collision test echoes transmit enable
// - status bits 14,13 read one
// - status bits 15,12 read zero
// - one register set shared by modes
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fiber_regs_defines.svh"
module fiber_sgmii_control_regs #(
    parameter int unsigned SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and datapath
    input wire fiber_regs_pkg::strap_type strap_pins,
    input wire logic mac_tx_en,
    input wire logic link_up,
    input wire logic negotiation_complete,
    input wire logic remote_fault,
    output logic mac_collision,
    output fiber_regs_pkg::path_ctrl_type path_ctrl
);
    typedef struct packed {
        logic [1:0] strap_sync;
        logic [1:0] strap_speed_h;
        logic [1:0] strap_speed_l;
        logic strap_done;
        logic [1:0] strap_wait;
        logic [15:0] link_loss;
        logic [15:0] fiber_path_control;
        fiber_regs_pkg::op_mode_type mode;
        logic aw_held;
        logic [13:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] st_sync;
        logic [1:0] sfault_sync;
        logic [1:0] sneg_sync;
        logic [1:0] txen_sync;
        logic collision;
        logic restart_pulse;
        fiber_regs_pkg::path_ctrl_type ctrl;
    } state_type;

    state_type st_ff;
    state_type nxt_st;
    logic rst_busy;
    logic rst_done;
    logic rst_start;
    logic do_write;
    logic [15:0] wval;
    logic [15:0] sts_val;

    // Every check below runs on mclk and sleeps through reset
    default clocking cb_chk @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // Soft reset timer
    // ------------------------------------------------------------------
    pulse_stretch #(
        .CYCLES(SOFT_RESET_CYCLES)
    ) u_soft_reset (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .start(rst_start),
        .busy(rst_busy),
        .done(rst_done)
    );

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    always_comb
    begin
        sts_val = `RST_FIBER_PATH_STATUS; // Capability bits are constants
        sts_val[5] = st_ff.sneg_sync[1];
        sts_val[4] = st_ff.sfault_sync[1];
        sts_val[2] = st_ff.st_sync[1];
    end

    assign do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    // Not restarted on the done cycle, or one write would reset twice
    assign rst_start = st_ff.fiber_path_control[`BIT_SOFT_RESET] && !rst_busy
                       && !rst_done;
    // Merge low byte lanes only; registers are 16 bits wide
    assign wval = {st_ff.w_strb[1] ? st_ff.w_data[15:8] : 8'h00,
                   st_ff.w_strb[0] ? st_ff.w_data[7:0] : 8'h00};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [15:0] keep;
        logic neg_en;
        keep = 16'h0000;
        neg_en = 1'b0;
        nxt_st = st_ff;
        nxt_st.restart_pulse = 1'b0;
        // Two-flop synchronisers for pin-level inputs
        nxt_st.strap_sync = {st_ff.strap_sync[0],
                             strap_pins.negotiation_enable};
        nxt_st.strap_speed_h = {st_ff.strap_speed_h[0],
                                strap_pins.speed_code_high};
        nxt_st.strap_speed_l = {st_ff.strap_speed_l[0],
                                strap_pins.speed_code_low};
        nxt_st.st_sync = {st_ff.st_sync[0], link_up};
        nxt_st.sfault_sync = {st_ff.sfault_sync[0], remote_fault};
        nxt_st.sneg_sync = {st_ff.sneg_sync[0], negotiation_complete};
        nxt_st.txen_sync = {st_ff.txen_sync[0], mac_tx_en};

        // Straps preset speed and negotiation once the synchronisers
        // hold the pin levels; a write in the same cycle still wins
        if (!st_ff.strap_done && st_ff.strap_wait != 2'h2)
            nxt_st.strap_wait = st_ff.strap_wait + 2'h1;
        else if (!st_ff.strap_done)
        begin
            nxt_st.strap_done = 1'b1;
            nxt_st.fiber_path_control[`BIT_SPEED_HIGH] = st_ff.strap_speed_h[1];
            nxt_st.fiber_path_control[`BIT_SPEED_LOW] = st_ff.strap_speed_l[1];
            nxt_st.fiber_path_control[`BIT_NEG_EN] = st_ff.strap_sync[1];
        end

        // Write address / data capture, either order
        if (s_axi_awvalid && !st_ff.aw_held)
        begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_held)
        begin
            nxt_st.w_held = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end

        // Register write; one shared bank for all modes
        if (do_write)
        begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `RESP_OKAY;
            keep = {st_ff.w_strb[1] ? 8'h00 : 8'hff,
                    st_ff.w_strb[0] ? 8'h00 : 8'hff};
            unique case (st_ff.aw_addr)
                `ADDR_LINK_LOSS:
                    // Reserved bits store what is written
                    nxt_st.link_loss = (st_ff.link_loss & keep) | wval;
                `ADDR_FIBER_PATH_CONTROL:
                begin
                    nxt_st.fiber_path_control = (st_ff.fiber_path_control & keep) | wval;
                    // Restart strobe, bit clears itself next cycle
                    nxt_st.restart_pulse = wval[`BIT_NEG_RESTART];
                end
                `ADDR_MODE_CFG:
                    nxt_st.mode = fiber_regs_pkg::op_mode_type'(wval[2:0]);
                `ADDR_FIBER_PATH_STATUS:
                    nxt_st.bresp = `RESP_OKAY;
                default:
                    nxt_st.bresp = `RESP_SLVERR;
            endcase
        end
        if (st_ff.restart_pulse)
            nxt_st.fiber_path_control[`BIT_NEG_RESTART] = 1'b0;
        // Self-clear after reset completes; a fresh write wins
        if (rst_done && !(do_write && st_ff.aw_addr == `ADDR_FIBER_PATH_CONTROL
                          && wval[`BIT_SOFT_RESET]))
            nxt_st.fiber_path_control[`BIT_SOFT_RESET] = 1'b0;
        if (st_ff.bvalid && s_axi_bready)
            nxt_st.bvalid = 1'b0;

        // Read channel
        if (s_axi_arvalid && !st_ff.rvalid)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = `RESP_OKAY;
            unique case (s_axi_araddr)
                `ADDR_LINK_LOSS: nxt_st.rdata = {16'h0000, st_ff.link_loss};
                `ADDR_FIBER_PATH_CONTROL: nxt_st.rdata = {16'h0000, st_ff.fiber_path_control};
                `ADDR_FIBER_PATH_STATUS: nxt_st.rdata = {16'h0000, sts_val};
                `ADDR_MODE_CFG: nxt_st.rdata = {29'h00000000, st_ff.mode};
                default:
                begin
                    nxt_st.rdata = 32'h00000000;
                    nxt_st.rresp = `RESP_SLVERR;
                end
            endcase
        end
        else if (st_ff.rvalid && s_axi_rready)
            nxt_st.rvalid = 1'b0;

        // Decoded controls
        neg_en = st_ff.fiber_path_control[`BIT_NEG_EN];
        nxt_st.ctrl.fiber_soft_reset = st_ff.fiber_path_control[`BIT_SOFT_RESET]
                                       || rst_busy;
        nxt_st.ctrl.mac_side_loopback = st_ff.fiber_path_control[`BIT_LOOPBACK];
        // Forced high bit ignored while negotiating
        nxt_st.ctrl.speed = fiber_regs_pkg::speed_code_type'(
            {st_ff.fiber_path_control[`BIT_SPEED_HIGH] && !neg_en,
             st_ff.fiber_path_control[`BIT_SPEED_LOW]});
        nxt_st.ctrl.negotiation_enable = neg_en;
        nxt_st.ctrl.serial_power_down = st_ff.fiber_path_control[`BIT_POWER_DOWN];
        nxt_st.ctrl.mac_port_isolate = st_ff.fiber_path_control[`BIT_ISOLATE]
            && st_ff.mode != fiber_regs_pkg::mode_serial_to_parallel_bridge;
        nxt_st.ctrl.negotiation_restart = st_ff.restart_pulse;
        // Half duplex only honoured in MII-FX mode
        nxt_st.ctrl.forced_duplex =
            (st_ff.mode == fiber_regs_pkg::mode_mii_hundred_fx)
            ? st_ff.fiber_path_control[`BIT_DUPLEX] : 1'b1;
        nxt_st.ctrl.link_loss_enable =
            !st_ff.link_loss[`BIT_LINK_LOSS_OFF];
        // Power down holds datapath in reset too
        if (st_ff.fiber_path_control[`BIT_POWER_DOWN])
            nxt_st.ctrl.fiber_soft_reset = 1'b1;
        nxt_st.collision = st_ff.fiber_path_control[`BIT_COL_TEST]
                           && st_ff.txen_sync[1];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '0;
            st_ff.link_loss <= `RST_LINK_LOSS;
            st_ff.fiber_path_control <= `RST_FIBER_PATH_CONTROL;
            st_ff.ctrl.speed <= fiber_regs_pkg::speed_hundred;
            st_ff.ctrl.negotiation_enable <= 1'b1;
            st_ff.ctrl.forced_duplex <= 1'b1;
        end
        else if (ce)
            st_ff <= nxt_st;
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign s_axi_awready = !st_ff.aw_held;
    assign s_axi_wready = !st_ff.w_held;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign mac_collision = st_ff.collision;
    assign path_ctrl = st_ff.ctrl;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Capability bits watched on the read path, where software sees them
    a_cap_bits: assert property (
        ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADDR_FIBER_PATH_STATUS
        |=> s_axi_rdata[14:13] == 2'h3)
        else $error("capability bits wrong");
    a_cap_zero: assert property (
        ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADDR_FIBER_PATH_STATUS
        |=> !s_axi_rdata[15] && !s_axi_rdata[12])
        else $error("unsupported set");
    a_restart_clear: assert property (
        ce && st_ff.restart_pulse |=> !st_ff.fiber_path_control[`BIT_NEG_RESTART])
        else $error("restart not cleared");
    a_soft_clear: assert property (
        ce && rst_done && !do_write |=> !st_ff.fiber_path_control[`BIT_SOFT_RESET])
        else $error("soft reset not cleared");
    a_reset_drives: assert property (
        ce && st_ff.fiber_path_control[15] |=> path_ctrl.fiber_soft_reset)
        else $error("soft reset not driven");
    a_power_reset: assert property (
        ce && st_ff.fiber_path_control[11] |=> path_ctrl.fiber_soft_reset
        && path_ctrl.serial_power_down)
        else $error("power down without reset");
    a_isolate_mode: assert property (
        ce && st_ff.mode == fiber_regs_pkg::mode_serial_to_parallel_bridge
        |=> !path_ctrl.mac_port_isolate)
        else $error("isolate leak");
    a_collision: assert property (
        ce && !st_ff.fiber_path_control[7] |=> !mac_collision)
        else $error("collision without test");
    a_collision_echo: assert property (
        ce && st_ff.fiber_path_control[7] && st_ff.txen_sync[1] |=> mac_collision)
        else $error("collision test silent");
    a_speed_neg: assert property (
        ce && st_ff.fiber_path_control[12] |=> !path_ctrl.speed[1])
        else $error("forced speed while negotiating");
    a_link_loss: assert property (
        ce |=> path_ctrl.link_loss_enable == !$past(st_ff.link_loss[0]))
        else $error("link loss mismatch");
    a_loopback_map: assert property (
        ce |=> path_ctrl.mac_side_loopback == $past(st_ff.fiber_path_control[14]))
        else $error("loopback not mapped");
    a_duplex_full: assert property (
        ce && st_ff.mode != fiber_regs_pkg::mode_mii_hundred_fx
        |=> path_ctrl.forced_duplex)
        else $error("half duplex outside mii mode");
    c_write: cover property (@(posedge mclk) do_write);
    c_read: cover property (@(posedge mclk) s_axi_rvalid && s_axi_rready);
    c_soft_reset: cover property (@(posedge mclk) rst_done);
    c_collision: cover property (@(posedge mclk) mac_collision);
    c_strap_load: cover property (@(posedge mclk)
        !st_ff.strap_done ##1 st_ff.strap_done);
endmodule : fiber_sgmii_control_regs

// ===== verif/tb_fiber_sgmii_control_regs.sv
// Self-checking bench for the fiber path register bank
`timescale 1ns/1ps
module tb_fiber_sgmii_control_regs;
    // ------------------------------------------------------------------
    // Addresses, port signals and scoreboard
    // ------------------------------------------------------------------
    localparam logic [13:0] addr_loss = 14'h07b0;
    localparam logic [13:0] addr_ctrl = 14'h3000;
    localparam logic [13:0] addr_stat = 14'h3004;
    localparam logic [13:0] addr_mode = 14'h3040;
    localparam logic [13:0] addr_hole = 14'h0008;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [13:0] s_axi_awaddr = 14'h0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [13:0] s_axi_araddr = 14'h0000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    fiber_regs_pkg::strap_type strap_pins = 3'b101;
    logic mac_tx_en = 1'b0;
    logic link_up = 1'b0;
    logic negotiation_complete = 1'b0;
    logic remote_fault = 1'b0;
    logic mac_collision;
    fiber_regs_pkg::path_ctrl_type path_ctrl;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    logic soft_seen = 1'b0;
    logic restart_seen = 1'b0;
    logic [15:0] val;

    // Small soft-reset count keeps the self-clear wait short
    fiber_sgmii_control_regs #(.SOFT_RESET_CYCLES(2)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .strap_pins(strap_pins),
        .mac_tx_en(mac_tx_en), .link_up(link_up),
        .negotiation_complete(negotiation_complete),
        .remote_fault(remote_fault), .mac_collision(mac_collision),
        .path_ctrl(path_ctrl)
    );

    always #25 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // Address and data offered together, each dropped once taken
    task automatic axi_write(input logic [13:0] a, input logic [15:0] d,
                             input logic [1:0] r);
        exp_b.push_back(r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [13:0] a, input logic [15:0] d,
                            input logic [1:0] r);
        exp_r.push_back({r, 16'h0000, d});
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic settle();
        repeat (4) @(posedge mclk);
    endtask : settle

    // ------------------------------------------------------------------
    // Monitor: answers are matched against the oldest note
    // ------------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            if (exp_r.size() == 0)
                chk("read_unexpected", 32'h0, 32'h1);
            else
            begin
                chk("rresp", {30'h0, exp_r[0][33:32]}, {30'h0, s_axi_rresp});
                chk("rdata", exp_r[0][31:0], s_axi_rdata);
            end
            if (exp_r.size() != 0)
                void'(exp_r.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            if (exp_b.size() == 0)
                chk("write_unexpected", 32'h0, 32'h1);
            else
                chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
        end
        if (path_ctrl.fiber_soft_reset === 1'b1)
            soft_seen <= 1'b1;
        if (path_ctrl.negotiation_restart === 1'b1)
            restart_seen <= 1'b1;
    end

    // Hang guard: the whole run needs a few hundred cycles
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h8c37));
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        settle();
        axi_read(addr_loss, 16'h1ffd, 2'h0);
        axi_read(addr_ctrl, 16'h1140, 2'h0);
        axi_read(addr_stat, 16'h6149, 2'h0);
        chk("link_loss_en", 32'h0, {31'h0, path_ctrl.link_loss_enable});
        // Random reserved bits must read back; bit 0 drives the feature
        repeat (3)
        begin
            val = 16'($urandom());
            axi_write(addr_loss, val, 2'h0);
            axi_read(addr_loss, val, 2'h0);
            settle();
            chk("link_loss_en", {31'h0, ~val[0]},
                {31'h0, path_ctrl.link_loss_enable});
        end
        // Soft reset and restart read back as zero after self-clear
        axi_write(addr_ctrl, 16'h9140, 2'h0);
        repeat (10) @(posedge mclk);
        chk("soft_reset_seen", 32'h1, {31'h0, soft_seen});
        chk("soft_reset_end", 32'h0, {31'h0, path_ctrl.fiber_soft_reset});
        axi_read(addr_ctrl, 16'h1140, 2'h0);
        axi_write(addr_ctrl, 16'h1340, 2'h0);
        settle();
        chk("restart_seen", 32'h1, {31'h0, restart_seen});
        axi_read(addr_ctrl, 16'h1140, 2'h0);
        // Every speed code forced with negotiation off
        for (int c = 0; c < 4; c++)
        begin
            val = 16'h0100 | (16'(c >> 1) << 6) | (16'(c & 1) << 13);
            axi_write(addr_ctrl, val, 2'h0);
            axi_read(addr_ctrl, val, 2'h0);
            settle();
            chk("speed", 32'(c), {30'h0, path_ctrl.speed});
            chk("neg_en", 32'h0, {31'h0, path_ctrl.negotiation_enable});
        end
        // High speed bit ignored while negotiating
        axi_write(addr_ctrl, 16'h3140, 2'h0);
        settle();
        chk("speed_neg", 32'h1, {30'h0, path_ctrl.speed});
        chk("neg_en", 32'h1, {31'h0, path_ctrl.negotiation_enable});
        // One register set in every mode; mode decides duplex and isolate
        for (int m = 0; m < 6; m++)
        begin
            axi_write(addr_mode, 16'(m), 2'h0);
            axi_read(addr_mode, 16'(m), 2'h0);
            axi_write(addr_ctrl, 16'h4c00, 2'h0);
            axi_read(addr_ctrl, 16'h4c00, 2'h0);
            settle();
            chk("duplex", {31'h0, m != 2}, {31'h0, path_ctrl.forced_duplex});
            chk("isolate", {31'h0, m != 4},
                {31'h0, path_ctrl.mac_port_isolate});
            chk("power_down", 32'h1, {31'h0, path_ctrl.serial_power_down});
            chk("loopback", 32'h1, {31'h0, path_ctrl.mac_side_loopback});
        end
        axi_write(addr_ctrl, 16'h0100, 2'h0);
        settle();
        chk("loopback_off", 32'h0, {31'h0, path_ctrl.mac_side_loopback});
        chk("power_up", 32'h0, {31'h0, path_ctrl.serial_power_down});
        // Collision test follows transmit enable
        axi_write(addr_ctrl, 16'h0180, 2'h0);
        mac_tx_en <= 1'b1;
        settle();
        chk("collision_on", 32'h1, {31'h0, mac_collision});
        mac_tx_en <= 1'b0;
        settle();
        chk("collision_idle", 32'h0, {31'h0, mac_collision});
        axi_write(addr_ctrl, 16'h0100, 2'h0);
        mac_tx_en <= 1'b1;
        settle();
        chk("collision_off", 32'h0, {31'h0, mac_collision});
        // Status: live bits follow pins, write has no effect
        link_up <= 1'b1;
        remote_fault <= 1'b1;
        negotiation_complete <= 1'b1;
        settle();
        axi_write(addr_stat, 16'hffff, 2'h0);
        axi_read(addr_stat, 16'h617d, 2'h0);
        // Second reset with other straps; preset lands in the control word
        strap_pins <= 3'b010;
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        settle();
        axi_read(addr_ctrl, 16'h2100, 2'h0);
        chk("speed_strap", 32'h1, {30'h0, path_ctrl.speed});
        // Unmapped place refused both ways
        axi_write(addr_hole, 16'h1234, 2'h2);
        axi_read(addr_hole, 16'h0000, 2'h2);
        settle();
        tally_and_finish();
    end
endmodule : tb_fiber_sgmii_control_regs
